// ### rtl/pdc_pkg.sv
// power-down controller constants: register map, field positions, reset values, modes
// assumes a word-aligned 32-bit register bus with byte addresses
package pdc_pkg;
  // register byte offsets
  localparam logic [4:0] PDC_OFF_SBY  = 5'h00;  // standby_ctl_reg
  localparam logic [4:0] PDC_OFF_SYS  = 5'h04;  // system_ctl_reg
  localparam logic [4:0] PDC_OFF_WCS  = 5'h08;  // wdt_ctl_status
  localparam logic [4:0] PDC_OFF_WCNT = 5'h0C;  // wdt_counter
  localparam logic [4:0] PDC_OFF_WRST = 5'h10;  // wdt_reset_ctl_status
  localparam logic [4:0] PDC_OFF_ICR  = 5'h14;  // irq_ctl_reg
  localparam logic [4:0] PDC_OFF_STAT = 5'h18;  // current power mode
  // reset values
  localparam logic [7:0] PDC_SBY_RST  = 8'h1F;
  localparam logic [7:0] PDC_SYS_RST  = 8'h01;
  localparam logic [7:0] PDC_WRST_RST = 8'h00;
  // field positions
  localparam int PDC_SBY_SEL  = 7;
  localparam int PDC_SBY_HIZ  = 6;
  localparam int PDC_SYS_ONCHIP_MEM_ON = 0;
  localparam int PDC_WCS_OVF  = 7;
  localparam int PDC_WCS_MODE = 6;
  localparam int PDC_WCS_RUN  = 5;
  localparam int PDC_ICR_NMI_EDGE_SELECT = 0;
  // watchdog sizes
  localparam int PDC_WCNT_W   = 8;
  localparam int PDC_WPRE_W   = 9;
  // power modes
  typedef enum logic [1:0] {
    PDC_RUN,
    PDC_SLEEP,
    PDC_STBY,
    PDC_WAKE
  } pdc_mode_t;
endpackage : pdc_pkg

// ### rtl/pdc_wdt_if.sv
// watchdog control bundle between controller and watchdog counter
// assumes both ends share one clock
`timescale 1ns/1ns
interface pdc_wdt_if #(parameter int CW = 8);
  logic [2:0]    cks;
  logic          count_en;
  logic          clear;
  logic          load;
  logic [CW-1:0] load_val;
  logic [CW-1:0] cnt;
  logic          ovf_tick;
  modport ctl (output cks, count_en, clear, load, load_val, input cnt, ovf_tick);
  modport tmr (input cks, count_en, clear, load, load_val, output cnt, ovf_tick);
endinterface : pdc_wdt_if

// ### rtl/pdc_wdt.sv
// watchdog prescaler and up-counter with overflow tick
// assumes clear and load come from the controller, clear taking priority
`timescale 1ns/1ns
module pdc_wdt
  import pdc_pkg::*;
#(
  parameter int PW = PDC_WPRE_W,
  parameter int CW = PDC_WCNT_W
) (
  input  wire logic clock,
  input  wire logic rstn,
  pdc_wdt_if.tmr    w
);
  logic [PW-1:0] pre_q;
  logic [CW-1:0] cnt_q;
  logic [PW-1:0] mask;
  logic          tick;

  // divide by 2^(cks+1)
  assign mask = ~({PW{1'b1}} << ({1'b0, w.cks} + 4'h1));
  assign tick = w.count_en && ((pre_q & mask) == mask);
  assign w.ovf_tick = tick && (&cnt_q);
  assign w.cnt = cnt_q;

  // prescaler
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_q <= '0;
    end else if (w.clear) begin
      pre_q <= '0;
    end else if (w.count_en) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // counter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (w.clear) begin
      cnt_q <= '0;
    end else if (w.load) begin
      cnt_q <= w.load_val;
    end else if (tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule : pdc_wdt

// ### rtl/pdc_edge.sv
// selectable-edge detector, one-cycle pulse
// assumes the input is synchronous to clock
`timescale 1ns/1ns
module pdc_edge (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic sig,
  input  wire logic rise_sel,
  output logic      edge_pulse
);
  logic prev_q;
  logic armed_q;

  // previous sample, armed after first clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prev_q  <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      prev_q  <= sig;
      armed_q <= 1'b1;
    end
  end

  assign edge_pulse = armed_q && (rise_sel ? (sig && !prev_q) : (!sig && prev_q));
endmodule : pdc_edge

// ### rtl/pdc_ctrl.sv
// power-down controller: hardware standby, software standby, sleep
// assumes an Avalon-MM master, inputs synchronous to clock, clock running while
// the two reset pins are released
//
// Function
// - standby pin low halts everything asynchronously
// - standby high, reset low restarts oscillator
// - reset rising edge starts reset exception
// - halt with select set enters software standby
// - standby keeps CPU registers and RAM
// - ports hold or float per float bit
// - standby entry initialises listed peripheral units
// - standby clears watchdog bits 7-5, counter
// - selected NMI edge clocks only the watchdog
// - watchdog overflow resumes chip, starts NMI exception
// - power-on or manual reset cancels standby
// - halt with select clear enters sleep
// - accepted enabled interrupt above mask ends sleep
// - DMA address error ends sleep
// - power-on reset ends sleep
// - RAM enable resets to one, enables RAM
// - select and float refuse set while watchdog runs
// - standby register resets 1F, bits 7,6
// - RAM disabled ignores writes, reads undefined
`timescale 1ns/1ns
module pdc_ctrl
  import pdc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        deep_halt_pin_n,
  input  wire logic        power_on_clear_n,
  input  wire logic        manual_reset_n,
  input  wire logic        halt_exec,
  input  wire logic        nmi_pin,
  input  wire logic        irq_req,
  input  wire logic [3:0]  irq_level,
  input  wire logic [3:0]  cpu_mask,
  input  wire logic        irq_periph_en,
  input  wire logic        dma_addr_err,
  output logic             osc_run,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             wdt_clk_en,
  output logic             periph_init,
  output logic             port_float,
  output logic             port_hold,
  output logic             onchip_mem_on,
  output logic             ram_access_ok,
  output logic             reset_exc_start,
  output logic             nmi_exc_start,
  output logic             irq_exc_start,
  output logic             dma_err_exc_start,
  output logic [1:0]       power_mode
);
  pdc_wdt_if #(.CW(PDC_WCNT_W)) wdt_bus ();

  logic            chip_rst_n;
  pdc_mode_t       mode_q;
  logic            sel_q;
  logic            hiz_q;
  logic            onchip_mem_on_q;
  logic            ovf_q;
  logic            wmode_q;
  logic            wrun_q;
  logic [2:0]      cks_q;
  logic [7:0]      wrst_q;
  logic            nmi_edge_select_q;
  logic            ack_q;
  logic [31:0]     rdata_q;
  logic [31:0]     rd_mux;
  logic            wr_go;
  logic            nmi_edge;
  logic            enter_stby;
  logic            enter_sleep;
  logic            irq_accept;
  logic            por_done_q;
  logic            rexc_q;
  logic            nexc_q;
  logic            iexc_q;
  logic            dexc_q;
  logic            pinit_q;
  logic            mo_n;

  // either pin low holds the whole block in reset, with no clock needed
  assign chip_rst_n = rstn && deep_halt_pin_n && power_on_clear_n;

  // bus handshake: one wait state per request
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_go = avs_write && ack_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  // read multiplexer, unmapped reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      PDC_OFF_SBY:  rd_mux[7:0] = {sel_q, hiz_q, PDC_SBY_RST[5:0]};
      PDC_OFF_SYS:  rd_mux[7:0] = {7'h00, onchip_mem_on_q};
      PDC_OFF_WCS:  rd_mux[7:0] = {ovf_q, wmode_q, wrun_q, 2'h3, cks_q};
      PDC_OFF_WCNT: rd_mux[PDC_WCNT_W-1:0] = wdt_bus.cnt;
      PDC_OFF_WRST: rd_mux[7:0] = wrst_q;
      PDC_OFF_ICR:  rd_mux[7:0] = {7'h00, nmi_edge_select_q};
      PDC_OFF_STAT: rd_mux[7:0] = {6'h00, mode_q};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured while waitrequest is high
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rd_mux;
    end
  end

  // halt instruction decode, ignored outside run
  // a manual reset in the same cycle wins, so standby is never half entered
  assign enter_stby  = (mode_q == PDC_RUN) && halt_exec && sel_q && mo_n;
  assign enter_sleep = (mode_q == PDC_RUN) && halt_exec && !sel_q && mo_n;
  assign irq_accept  = irq_req && irq_periph_en && (irq_level > cpu_mask);
  assign mo_n        = manual_reset_n;

  // standby control register
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      sel_q <= PDC_SBY_RST[PDC_SBY_SEL];
      hiz_q <= PDC_SBY_RST[PDC_SBY_HIZ];
    end else if (wr_go && avs_address == PDC_OFF_SBY) begin
      sel_q <= avs_writedata[PDC_SBY_SEL] && !wrun_q;
      hiz_q <= avs_writedata[PDC_SBY_HIZ] && !wrun_q;
    end
  end

  // system control register, RAM enable
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      onchip_mem_on_q <= PDC_SYS_RST[PDC_SYS_ONCHIP_MEM_ON];
    end else if (wr_go && avs_address == PDC_OFF_SYS) begin
      onchip_mem_on_q <= avs_writedata[PDC_SYS_ONCHIP_MEM_ON];
    end
  end

  // RAM gate: kept in standby and sleep, cut only by the enable bit
  assign onchip_mem_on = onchip_mem_on_q;
  assign ram_access_ok = onchip_mem_on_q;

  // interrupt control, NMI edge select
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      nmi_edge_select_q <= 1'b0;
    end else if (wr_go && avs_address == PDC_OFF_ICR) begin
      nmi_edge_select_q <= avs_writedata[PDC_ICR_NMI_EDGE_SELECT];
    end
  end

  // overflow flag; the set wins over a software write-0 clear in the same cycle
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      ovf_q <= 1'b0;
    end else if (enter_stby) begin
      ovf_q <= 1'b0;
    end else if (wdt_bus.ovf_tick && mode_q == PDC_RUN) begin
      ovf_q <= 1'b1;
    end else if (wr_go && avs_address == PDC_OFF_WCS && !avs_writedata[PDC_WCS_OVF]) begin
      ovf_q <= 1'b0;
    end
  end

  // watchdog mode and run bits, cleared on standby entry
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      wmode_q <= 1'b0;
      wrun_q  <= 1'b0;
    end else if (enter_stby) begin
      wmode_q <= 1'b0;
      wrun_q  <= 1'b0;
    end else if (wr_go && avs_address == PDC_OFF_WCS) begin
      wmode_q <= avs_writedata[PDC_WCS_MODE];
      wrun_q  <= avs_writedata[PDC_WCS_RUN];
    end
  end

  // clock select survives standby so the wake-up period stays as programmed
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      cks_q <= 3'h0;
    end else if (wr_go && avs_address == PDC_OFF_WCS) begin
      cks_q <= avs_writedata[2:0];
    end
  end

  // watchdog reset control/status
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      wrst_q <= PDC_WRST_RST;
    end else if (enter_stby) begin
      wrst_q <= PDC_WRST_RST;
    end else if (wr_go && avs_address == PDC_OFF_WRST) begin
      wrst_q <= avs_writedata[7:0];
    end
  end

  // watchdog drive: counts when enabled, or alone during standby wake-up
  assign wdt_bus.cks      = cks_q;
  assign wdt_bus.count_en = (wrun_q && mode_q != PDC_STBY) || (mode_q == PDC_WAKE);
  assign wdt_bus.clear    = enter_stby;
  assign wdt_bus.load     = wr_go && (avs_address == PDC_OFF_WCNT);
  assign wdt_bus.load_val = avs_writedata[PDC_WCNT_W-1:0];

  pdc_wdt #(
    .PW (PDC_WPRE_W),
    .CW (PDC_WCNT_W)
  ) u_wdt (
    .clock (clock),
    .rstn  (chip_rst_n),
    .w     (wdt_bus)
  );

  pdc_edge u_nmi_edge (
    .clock      (clock),
    .rstn       (chip_rst_n),
    .sig        (nmi_pin),
    .rise_sel   (nmi_edge_select_q),
    .edge_pulse (nmi_edge)
  );

  // power mode sequencer
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      mode_q <= PDC_RUN;
    end else if (!mo_n) begin
      mode_q <= PDC_RUN;
    end else begin
      case (mode_q)
        PDC_RUN: begin
          if (enter_stby) begin
            mode_q <= PDC_STBY;
          end else if (enter_sleep) begin
            mode_q <= PDC_SLEEP;
          end
        end
        PDC_SLEEP: begin
          if (dma_addr_err || irq_accept) begin
            mode_q <= PDC_RUN;
          end
        end
        PDC_STBY: begin
          if (nmi_edge) begin
            mode_q <= PDC_WAKE;
          end
        end
        PDC_WAKE: begin
          if (wdt_bus.ovf_tick) begin
            mode_q <= PDC_RUN;
          end
        end
        default: mode_q <= PDC_RUN;
      endcase
    end
  end

  // nmi exception start as the wake-up overflow releases the chip
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      nexc_q <= 1'b0;
    end else begin
      nexc_q <= mo_n && (mode_q == PDC_WAKE) && wdt_bus.ovf_tick;
    end
  end

  // dma address error exception, outranks an interrupt in the same cycle
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      dexc_q <= 1'b0;
    end else begin
      dexc_q <= mo_n && (mode_q == PDC_SLEEP) && dma_addr_err;
    end
  end

  // interrupt exception, only when no dma error leaves sleep first
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      iexc_q <= 1'b0;
    end else begin
      iexc_q <= mo_n && (mode_q == PDC_SLEEP) && !dma_addr_err && irq_accept;
    end
  end

  // marks that the first clock after both pins release has passed
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      por_done_q <= 1'b0;
    end else begin
      por_done_q <= 1'b1;
    end
  end

  // reset exception once, on the first clock after both pins release
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      rexc_q <= 1'b0;
    end else begin
      rexc_q <= !por_done_q;
    end
  end

  // peripheral initialise pulse on standby entry
  always_ff @(posedge clock or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      pinit_q <= 1'b0;
    end else begin
      pinit_q <= enter_stby && mo_n;
    end
  end

  // clock enables, forced off while either pin is low; osc_run is forced off only by the standby pin
  assign osc_run = deep_halt_pin_n && (mode_q != PDC_STBY);
  assign cpu_clk_en = chip_rst_n && (mode_q == PDC_RUN);
  assign periph_clk_en = chip_rst_n && (mode_q == PDC_RUN || mode_q == PDC_SLEEP);
  assign wdt_clk_en = chip_rst_n && (mode_q != PDC_STBY);

  // port pins in software standby
  assign port_float = (mode_q == PDC_STBY || mode_q == PDC_WAKE) && hiz_q;
  assign port_hold  = (mode_q == PDC_STBY || mode_q == PDC_WAKE) && !hiz_q;

  assign periph_init       = pinit_q;
  assign reset_exc_start   = rexc_q;
  assign nmi_exc_start     = nexc_q;
  assign irq_exc_start     = iexc_q;
  assign dma_err_exc_start = dexc_q;
  assign power_mode        = mode_q;
endmodule : pdc_ctrl

// ### verification/pdc_ctrl_asserts.sv
// checker on the power-down controller top ports
// assumes binding into pdc_ctrl, one clock domain
`timescale 1ns/1ns
module pdc_chk (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       deep_halt_pin_n,
  input wire logic       power_on_clear_n,
  input wire logic       manual_reset_n,
  input wire logic       halt_exec,
  input wire logic       irq_req,
  input wire logic [3:0] irq_level,
  input wire logic [3:0] cpu_mask,
  input wire logic       irq_periph_en,
  input wire logic       dma_addr_err,
  input wire logic       osc_run,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       wdt_clk_en,
  input wire logic       periph_init,
  input wire logic       onchip_mem_on,
  input wire logic       reset_exc_start,
  input wire logic       nmi_exc_start,
  input wire logic       irq_exc_start,
  input wire logic       dma_err_exc_start,
  input wire logic [1:0] power_mode
);
  // resets released, interrupt accepted, halt taken in run
  wire rel = rstn & deep_halt_pin_n & power_on_clear_n;
  wire acc = irq_req & irq_periph_en & (irq_level > cpu_mask);
  wire go  = halt_exec & manual_reset_n & (power_mode == 2'h0);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rel);
  chk_halt_leaves_run: assert property (go |=> power_mode inside {2'h1, 2'h2})
    else $error("halt did not leave run mode");
  chk_stby_init_pulse: assert property (go |=> periph_init == (power_mode == 2'h2))
    else $error("peripheral init pulse wrong");
  chk_stby_clocks_off: assert property (power_mode == 2'h2 |->
    !(cpu_clk_en | periph_clk_en | wdt_clk_en | osc_run)) else $error("clock on in standby");
  chk_wake_wdt_only: assert property (power_mode == 2'h3 |->
    wdt_clk_en & osc_run & !cpu_clk_en & !periph_clk_en) else $error("wake clocks wrong");
  chk_wake_nmi_exc: assert property ((power_mode == 2'h3 && manual_reset_n) ##1
    power_mode == 2'h0 |-> nmi_exc_start) else $error("no nmi start on wake");
  chk_irq_ends_sleep: assert property (power_mode == 2'h1 && acc && !dma_addr_err
    && manual_reset_n |=> power_mode == 2'h0 && irq_exc_start) else $error("irq kept sleep");
  chk_dma_ends_sleep: assert property (power_mode == 2'h1 && dma_addr_err && manual_reset_n
    |=> power_mode == 2'h0 && dma_err_exc_start && !irq_exc_start) else $error("dma exit wrong");
  chk_manual_cancel: assert property (!manual_reset_n |=>
    power_mode == 2'h0 && !nmi_exc_start) else $error("manual reset kept mode");
  chk_hw_standby: assert property (@(posedge clock) disable iff (!rstn)
    !deep_halt_pin_n |-> power_mode == 2'h0 && !osc_run && !cpu_clk_en && onchip_mem_on)
    else $error("standby pin did not halt");
  chk_reset_exc: assert property (rel && !$past(rel) |=>
    reset_exc_start ##1 !reset_exc_start) else $error("reset start pulse wrong");
endmodule : pdc_chk

bind pdc_ctrl pdc_chk pdc_chk_inst (.*);

// ### verification/pdc_supervisor.sv
// board supervisor model driving the standby and power-on reset pins
// assumes a one-cycle request: 1 hardware standby cycle, 2 reset pulse
`timescale 1ns/1ns
module pdc_supervisor #(
  parameter int HOLD   = 4,
  parameter int SETTLE = 20
) (
  input  wire logic       clock,
  input  wire logic [1:0] sup_req,
  output logic            sup_busy,
  output logic            deep_halt_pin_n,
  output logic            power_on_clear_n
);
  logic [1:0] k;
  // pin sequencing, reset always first and last
  initial begin
    sup_busy = 1'b0;
    deep_halt_pin_n = 1'b1;
    power_on_clear_n = 1'b1;
    forever begin
      @(posedge clock);
      k = sup_req;
      if (k != 2'h0) begin
        sup_busy <= 1'b1;
        power_on_clear_n <= 1'b0;
        repeat (HOLD) @(posedge clock);
        if (k == 2'h1) begin
          deep_halt_pin_n <= 1'b0;
          repeat (HOLD) @(posedge clock);
          deep_halt_pin_n <= 1'b1;
        end
        repeat (SETTLE) @(posedge clock);
        power_on_clear_n <= 1'b1;
        sup_busy <= 1'b0;
      end
    end
  end
endmodule : pdc_supervisor

// ### verification/pdc_ctrl_tb.sv
// self-checking bench for the power-down controller
// assumes the checker is bound and the supervisor model drives the pins
`timescale 1ns/1ns
module pdc_ctrl_tb
  import pdc_pkg::*;
;
  logic        clock, rstn, manual_reset_n, halt_exec, nmi_pin, irq_req, irq_periph_en;
  logic        dma_addr_err, avs_read, avs_write, avs_waitrequest, deep_halt_pin_n;
  logic        power_on_clear_n, osc_run, cpu_clk_en, periph_clk_en, wdt_clk_en;
  logic        periph_init, port_float, port_hold, onchip_mem_on, ram_access_ok;
  logic        nmi_exc_start, irq_exc_start, dma_err_exc_start, sup_busy, reset_exc_start;
  logic [1:0]  power_mode, sup_req;
  logic [3:0]  irq_level, cpu_mask;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  int          mismatches, samples_checked, n;

  pdc_ctrl pdc_ctrl_inst (.*);
  pdc_supervisor pdc_supervisor_inst (.*);

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : chk

  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chb

  // one bus cycle, held until waitrequest is sampled low at a rising edge, then one idle cycle
  task automatic bus(input logic rd, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    int k;
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    if (k >= 40) begin
      mismatches++;
      give_verdict();
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b1, a, 8'h00, q);
    chk("readdata", {24'h0, e}, {24'h0, q});
  endtask : rd

  // one event cycle, then mode and pulses {irq, dma, nmi, init}
  task automatic ev(input logic [1:0] m, input logic [3:0] p);
    @(posedge clock);
    halt_exec <= 1'b0;
    manual_reset_n <= 1'b1;
    dma_addr_err <= 1'b0;
    @(negedge clock);
    chk("power_mode", {30'h0, m}, {30'h0, power_mode});
    chk("pulses", {28'h0, p}, {28'h0, irq_exc_start, dma_err_exc_start, nmi_exc_start, periph_init});
    @(posedge clock);
  endtask : ev

  task automatic wt(input logic [1:0] m, input int lim);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (power_mode !== m && n < lim);
    if (n >= lim) begin
      mismatches++;
      give_verdict();
    end
  endtask : wt

  // supervisor request, watching the oscillator while the pins move
  task automatic sup(input logic [1:0] k);
    sup_req <= k;
    @(posedge clock);
    sup_req <= 2'h0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (!deep_halt_pin_n) chb("osc_run", 1'b0, osc_run);
      if (deep_halt_pin_n && !power_on_clear_n) chb("osc_run", 1'b1, osc_run);
    end while (sup_busy && n < 200);
    if (n >= 200) begin
      mismatches++;
      give_verdict();
    end
    @(negedge clock);
    chb("reset_exc_start", 1'b1, reset_exc_start);
    @(posedge clock);
  endtask : sup

  // main sequence
  initial begin
    mismatches = 0;
    samples_checked = 0;
    rstn = 1'b0;
    manual_reset_n = 1'b1;
    halt_exec = 1'b0;
    nmi_pin = 1'b0;
    irq_req = 1'b0;
    irq_level = 4'h0;
    cpu_mask = 4'h3;
    irq_periph_en = 1'b0;
    dma_addr_err = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    sup_req = 2'h0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    chb("reset_exc_start", 1'b0, reset_exc_start);
    @(negedge clock);
    chb("reset_exc_start", 1'b1, reset_exc_start);
    @(posedge clock);
    rd(PDC_OFF_SBY, 8'h1F);
    rd(PDC_OFF_SYS, 8'h01);
    rd(5'h1C, 8'h00);
    wr(PDC_OFF_WCS, 8'h20);
    wr(PDC_OFF_SBY, 8'hC0);
    rd(PDC_OFF_SBY, 8'h1F);
    wr(PDC_OFF_WCS, 8'h00);
    // sleep: masked, disabled, accepted, dma error, reset
    halt_exec <= 1'b1;
    ev(2'h1, 4'h0);
    chb("periph_clk_en", 1'b1, periph_clk_en);
    irq_req <= 1'b1;
    irq_level <= 4'h3;
    irq_periph_en <= 1'b1;
    ev(2'h1, 4'h0);
    irq_level <= 4'h4;
    irq_periph_en <= 1'b0;
    ev(2'h1, 4'h0);
    irq_periph_en <= 1'b1;
    ev(2'h0, 4'h8);
    irq_req <= 1'b0;
    halt_exec <= 1'b1;
    ev(2'h1, 4'h0);
    dma_addr_err <= 1'b1;
    irq_req <= 1'b1;
    ev(2'h0, 4'h4);
    irq_req <= 1'b0;
    halt_exec <= 1'b1;
    ev(2'h1, 4'h0);
    sup(2'h2);
    ev(2'h0, 4'h0);
    // software standby, rising edge wake after 256 * 2^3 cycles
    wr(PDC_OFF_WCS, 8'h42);
    wr(PDC_OFF_SBY, 8'hC0);
    wr(PDC_OFF_WCNT, 8'h55);
    wr(PDC_OFF_ICR, 8'h01);
    halt_exec <= 1'b1;
    ev(2'h2, 4'h1);
    chb("port_float", 1'b1, port_float);
    halt_exec <= 1'b1;
    ev(2'h2, 4'h0);
    rd(PDC_OFF_WCS, 8'h1A);
    rd(PDC_OFF_WCNT, 8'h00);
    rd(PDC_OFF_SBY, 8'hDF);
    nmi_pin <= 1'b1;
    wt(2'h3, 4);
    @(posedge clock);
    wt(2'h0, 3000);
    chb("nmi_exc_start", 1'b1, nmi_exc_start);
    chk("wake_time", 32'h0000_0800, n);
    @(posedge clock);
    // cancels by manual and power-on reset
    wr(PDC_OFF_SBY, 8'h80);
    nmi_pin <= 1'b0;
    halt_exec <= 1'b1;
    ev(2'h2, 4'h1);
    chb("port_hold", 1'b1, port_hold);
    manual_reset_n <= 1'b0;
    ev(2'h0, 4'h0);
    halt_exec <= 1'b1;
    ev(2'h2, 4'h1);
    sup(2'h2);
    ev(2'h0, 4'h0);
    // hardware standby from sleep with memory disabled
    halt_exec <= 1'b1;
    ev(2'h1, 4'h0);
    wr(PDC_OFF_SYS, 8'h00);
    chb("ram_access_ok", 1'b0, ram_access_ok);
    sup(2'h1);
    chb("onchip_mem_on", 1'b1, onchip_mem_on);
    ev(2'h0, 4'h0);
    give_verdict();
  end
endmodule : pdc_ctrl_tb
